// ===== design/adc_scan_pkg.sv
package adc_scan_pkg;

    // ------------------------------------------------------------
    // Special function register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL     = 8'hD7;
    localparam logic [7:0] ADDR_SCAN_SELECT = 8'hE7;
    localparam logic [7:0] ADDR_PORT        = 8'hC7;
    localparam logic [7:0] ADDR_RESULT_LOW0 = 8'hE8;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hDF;

    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int BIT_PRESCALE_HI = 7;
    localparam int BIT_PRESCALE_LO = 6;
    localparam int BIT_RESERVED    = 5;
    localparam int BIT_DONE        = 4;
    localparam int BIT_START       = 3;
    localparam int BIT_CONTINUOUS  = 2;
    localparam int BIT_RISE_EN     = 1;
    localparam int BIT_FALL_EN     = 0;

    localparam logic [7:0] CONTROL_RESET     = 8'h00;
    localparam logic [7:0] SCAN_SELECT_RESET = 8'h00;

    // ------------------------------------------------------------
    // Converter geometry and timing
    // ------------------------------------------------------------
    localparam int         CHANNELS       = 8;
    localparam int         RESULT_BITS    = 10;
    localparam logic [3:0] SAMPLE_PERIODS = 4'h2;
    localparam logic [3:0] TOP_BIT        = 4'h9;
    localparam int         MC_CLKS        = 12;

    typedef enum logic [2:0] {
        SCAN_IDLE = 3'b001,
        SCAN_CONV = 3'b010,
        SCAN_GAP  = 3'b100
    } scan_state_t;

    typedef enum logic [3:0] {
        SAR_IDLE   = 4'b0001,
        SAR_SAMPLE = 4'b0010,
        SAR_BITS   = 4'b0100,
        SAR_STORE  = 4'b1000
    } sar_state_t;

endpackage : adc_scan_pkg

// ===== design/sync_edge.sv
`timescale 1ns/1ps
module sync_edge #(
    parameter int W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] din_i,
    output logic      [W-1:0] q_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } sync_t;

    sync_t r;
    sync_t next_r;

    // First stage feeds only the second stage
    always_comb begin
        next_r    = r;
        next_r.s1 = din_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_o    = r.s2;
    assign rise_o = r.s2 & ~r.s3;
    assign fall_o = ~r.s2 & r.s3;

endmodule : sync_edge

// ===== design/sar_engine.sv
`timescale 1ns/1ps
module sar_engine (
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    input  wire logic       mc_en_i,
    input  wire logic [2:0] period_i,
    input  wire logic       start_i,
    input  wire logic       abort_i,
    input  wire logic       comp_i,
    output logic            busy_o,
    output logic            done_o,
    output logic      [9:0] result_o,
    output logic      [9:0] dac_code_o,
    output logic            sample_o
);

    typedef struct packed {
        adc_scan_pkg::sar_state_t st;
        logic [2:0]               cnt;
        logic [3:0]               bitn;
        logic [9:0]               code;
        logic [9:0]               result;
        logic                     done;
    } sar_t;

    sar_t       r;
    sar_t       next_r;
    logic       period_end;
    logic [3:0] lower_bit;

    assign period_end = mc_en_i && (r.cnt == period_i - 3'h1);
    assign lower_bit  = r.bitn - 4'h1;

    // ------------------------------------------------------------
    // Sample, ten bit trials, store: 2 + 10 periods of m/2 plus one
    // ------------------------------------------------------------
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        if (mc_en_i && r.st != adc_scan_pkg::SAR_IDLE) begin
            next_r.cnt = period_end ? 3'h0 : r.cnt + 3'h1;
        end
        if (abort_i) begin
            next_r.st   = adc_scan_pkg::SAR_IDLE;
            next_r.code = 10'h000;
        end else begin
            case (r.st)
                adc_scan_pkg::SAR_IDLE: begin
                    if (start_i) begin
                        next_r.st   = adc_scan_pkg::SAR_SAMPLE;
                        next_r.cnt  = 3'h0;
                        next_r.bitn = 4'h0;
                    end
                end
                adc_scan_pkg::SAR_SAMPLE: begin
                    if (period_end) begin
                        if (r.bitn == adc_scan_pkg::SAMPLE_PERIODS - 4'h1) begin
                            next_r.st   = adc_scan_pkg::SAR_BITS;
                            next_r.bitn = adc_scan_pkg::TOP_BIT;
                            next_r.code = 10'h200;
                        end else begin
                            next_r.bitn = r.bitn + 4'h1;
                        end
                    end
                end
                adc_scan_pkg::SAR_BITS: begin
                    if (period_end) begin
                        // Comparator low means the trial level overshot the input
                        if (!comp_i) begin
                            next_r.code[r.bitn] = 1'b0;
                        end
                        if (r.bitn == 4'h0) begin
                            next_r.st = adc_scan_pkg::SAR_STORE;
                        end else begin
                            next_r.code[lower_bit] = 1'b1;
                            next_r.bitn            = lower_bit;
                        end
                    end
                end
                adc_scan_pkg::SAR_STORE: begin
                    if (mc_en_i) begin
                        next_r.result = r.code;
                        next_r.done   = 1'b1;
                        next_r.st     = adc_scan_pkg::SAR_IDLE;
                    end
                end
                default: begin
                    next_r.st = adc_scan_pkg::SAR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '{st: adc_scan_pkg::SAR_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign busy_o     = (r.st != adc_scan_pkg::SAR_IDLE);
    assign done_o     = r.done;
    assign result_o   = r.result;
    assign dac_code_o = r.code;
    assign sample_o   = (r.st == adc_scan_pkg::SAR_SAMPLE);

endmodule : sar_engine

// ===== design/adc_autoscan_control.sv
// Operation
// - Ten-bit successive approximation on eight inputs
// - Per-channel result buffer written after conversion
// - Low bytes per channel, high bits shared
// - Prescaler divides by 2, 4, 6, 8
// - Done flag set after each complete loop
// - Interrupt request while flag and enable
// - Only written zero clears the done flag
// - Start bit set starts the scan
// - Continuous mode keeps start bit, repeats loop
// - One-time mode clears start bit at end
// - Start requests ignored while start bit set
// - Clearing start bit aborts running conversion
// - Scan-mode bit picks continuous or single pass
// - Enabled rising trigger edge starts, captures
// - Enabled falling trigger edge starts, captures
// - Reset clears the control register
// - Any subset of one to eight inputs
// - Port register returns digital pin levels
// - No selected channel refuses every start
// - Loop starts at lowest selected channel
// - Low-byte read latches that channel's high bits
// - Conversion takes six m plus one cycles
`timescale 1ns/1ps
module adc_autoscan_control #(
    parameter int MC_CLKS = adc_scan_pkg::MC_CLKS
) (
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       irq_en_i,
    output logic            irq_o,
    input  wire logic       external_trigger_in_i,
    output logic            capture_o,
    input  wire logic [7:0] shared_input_port_i,
    input  wire logic       comp_i,
    output logic      [9:0] dac_code_o,
    output logic      [2:0] mux_sel_o,
    output logic            sample_o
);

    // Comparator passes two sync stages, so the shortest bit period needs three clocks
    if (MC_CLKS < 3 || MC_CLKS > 16) begin : g_bad_mc
        $error("MC_CLKS must lie between 3 and 16");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        adc_scan_pkg::scan_state_t st;
        logic [1:0]                prescale;
        logic                      done_flag;
        logic                      start_status;
        logic                      continuous_scan_sel;
        logic                      trigger_rise_en;
        logic                      trigger_fall_en;
        logic [7:0]                scan_select;
        logic [7:0]                loop_mask;
        logic [2:0]                chan;
        logic [3:0]                mc_div;
        logic [2:0]                gap;
        logic                      sar_start;
        logic                      sar_abort;
        logic [7:0][9:0]           results;
        logic [1:0]                high_latch;
        logic [7:0]                rdata;
        logic                      capture;
        logic [7:0]                conv_mc;
    } ctl_t;

    ctl_t       r;
    ctl_t       next_r;

    logic       trig_rise;
    logic       trig_fall;
    logic       comp_s;
    logic [7:0] port_s;
    logic       mc_en;
    logic [2:0] period;
    logic       sar_busy;
    logic       sar_done;
    logic [9:0] sar_result;
    logic       ctl_wr;
    logic       hw_start;
    logic       start_req;
    logic [3:0] first_ch;
    logic [3:0] next_ch;

    // Returns {found, index} of the lowest set bit at or above from
    function automatic logic [3:0] lowest_from(input logic [7:0] mask, input logic [3:0] from);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (mask[i] && 4'(i) >= from) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction : lowest_from

    // ------------------------------------------------------------
    // Pin synchronisers and converter core
    // ------------------------------------------------------------
    sync_edge #(.W(1)) u_trig_sync (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .din_i   (external_trigger_in_i),
        .q_o     (),
        .rise_o  (trig_rise),
        .fall_o  (trig_fall)
    );

    sync_edge #(.W(1)) u_comp_sync (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .din_i   (comp_i),
        .q_o     (comp_s),
        .rise_o  (),
        .fall_o  ()
    );

    sync_edge #(.W(8)) u_port_sync (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .din_i   (shared_input_port_i),
        .q_o     (port_s),
        .rise_o  (),
        .fall_o  ()
    );

    sar_engine u_sar (
        .clock_i    (clock_i),
        .rst_b_i    (rst_b_i),
        .mc_en_i    (mc_en),
        .period_i   (period),
        .start_i    (r.sar_start),
        .abort_i    (r.sar_abort),
        .comp_i     (comp_s),
        .busy_o     (sar_busy),
        .done_o     (sar_done),
        .result_o   (sar_result),
        .dac_code_o (dac_code_o),
        .sample_o   (sample_o)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign mc_en     = (r.mc_div == 4'(MC_CLKS - 1));
    assign period    = {1'b0, r.prescale} + 3'h1;
    assign ctl_wr    = sfr_wr_i && (sfr_addr_i == adc_scan_pkg::ADDR_CONTROL);
    assign hw_start  = (trig_rise && r.trigger_rise_en) || (trig_fall && r.trigger_fall_en);
    assign start_req = (ctl_wr && sfr_wdata_i[adc_scan_pkg::BIT_START]) || hw_start;
    assign first_ch  = lowest_from(r.scan_select, 4'h0);
    assign next_ch   = lowest_from(r.loop_mask, {1'b0, r.chan} + 4'h1);

    always_comb begin
        next_r           = r;
        next_r.sar_start = 1'b0;
        next_r.sar_abort = 1'b0;
        next_r.capture   = hw_start;
        next_r.mc_div    = mc_en ? 4'h0 : r.mc_div + 4'h1;

        if (r.sar_start) begin
            next_r.conv_mc = 8'h00;
        end else if (mc_en && sar_busy) begin
            next_r.conv_mc = r.conv_mc + 8'h01;
        end

        // Reserved bit is not stored, so it always reads zero
        if (ctl_wr) begin
            next_r.prescale            = sfr_wdata_i[adc_scan_pkg::BIT_PRESCALE_HI:adc_scan_pkg::BIT_PRESCALE_LO];
            next_r.continuous_scan_sel = sfr_wdata_i[adc_scan_pkg::BIT_CONTINUOUS];
            next_r.trigger_rise_en     = sfr_wdata_i[adc_scan_pkg::BIT_RISE_EN];
            next_r.trigger_fall_en     = sfr_wdata_i[adc_scan_pkg::BIT_FALL_EN];
            if (!sfr_wdata_i[adc_scan_pkg::BIT_DONE]) begin
                next_r.done_flag = 1'b0;
            end
        end
        if (sfr_wr_i && sfr_addr_i == adc_scan_pkg::ADDR_SCAN_SELECT) begin
            next_r.scan_select = sfr_wdata_i;
        end

        // --------------------------------------------------------
        // Scan sequencer; a new scan select applies from the next loop
        // --------------------------------------------------------
        case (r.st)
            adc_scan_pkg::SCAN_IDLE: begin
            end
            adc_scan_pkg::SCAN_CONV: begin
                if (sar_done) begin
                    next_r.results[r.chan] = sar_result;
                    next_r.gap             = 3'((period << 1) - 3'h1);
                    if (next_ch[3]) begin
                        next_r.chan = next_ch[2:0];
                        next_r.st   = adc_scan_pkg::SCAN_GAP;
                    end else begin
                        next_r.done_flag = 1'b1;
                        if (r.continuous_scan_sel && first_ch[3]) begin
                            next_r.loop_mask = r.scan_select;
                            next_r.chan      = first_ch[2:0];
                            next_r.st        = adc_scan_pkg::SCAN_GAP;
                        end else begin
                            next_r.start_status = 1'b0;
                            next_r.st           = adc_scan_pkg::SCAN_IDLE;
                        end
                    end
                end
            end
            adc_scan_pkg::SCAN_GAP: begin
                // Channel switch time pads each slot to seven m cycles
                if (mc_en) begin
                    if (r.gap == 3'h1) begin
                        next_r.st        = adc_scan_pkg::SCAN_CONV;
                        next_r.sar_start = 1'b1;
                    end else begin
                        next_r.gap = r.gap - 3'h1;
                    end
                end
            end
            default: begin
                next_r.st = adc_scan_pkg::SCAN_IDLE;
            end
        endcase

        // --------------------------------------------------------
        // Start and abort take priority over the sequencer
        // --------------------------------------------------------
        if (!r.start_status) begin
            if (start_req && r.scan_select != 8'h00) begin
                next_r.start_status = 1'b1;
                next_r.loop_mask    = r.scan_select;
                next_r.chan         = first_ch[2:0];
                next_r.st           = adc_scan_pkg::SCAN_CONV;
                next_r.sar_start    = 1'b1;
            end
        end else if (ctl_wr && !sfr_wdata_i[adc_scan_pkg::BIT_START]) begin
            next_r.start_status = 1'b0;
            next_r.st           = adc_scan_pkg::SCAN_IDLE;
            next_r.sar_abort    = 1'b1;
        end

        // --------------------------------------------------------
        // Register reads, answered one cycle later
        // --------------------------------------------------------
        if (sfr_rd_i) begin
            if (sfr_addr_i[7:3] == adc_scan_pkg::ADDR_RESULT_LOW0[7:3]) begin
                next_r.rdata      = r.results[sfr_addr_i[2:0]][7:0];
                next_r.high_latch = r.results[sfr_addr_i[2:0]][9:8];
            end else begin
                case (sfr_addr_i)
                    adc_scan_pkg::ADDR_CONTROL:     next_r.rdata = {r.prescale, 1'b0, r.done_flag, r.start_status,
                                                                    r.continuous_scan_sel, r.trigger_rise_en,
                                                                    r.trigger_fall_en};
                    adc_scan_pkg::ADDR_SCAN_SELECT: next_r.rdata = r.scan_select;
                    adc_scan_pkg::ADDR_PORT:        next_r.rdata = port_s;
                    adc_scan_pkg::ADDR_RESULT_HIGH: next_r.rdata = {6'h00, r.high_latch};
                    default:                        next_r.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '{st: adc_scan_pkg::SCAN_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign sfr_rdata_o = r.rdata;
    assign irq_o       = r.done_flag && irq_en_i;
    assign capture_o   = r.capture;
    assign mux_sel_o   = r.chan;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    property p_result_store;
        sar_done && r.st == adc_scan_pkg::SCAN_CONV |=> r.results[$past(r.chan)] == $past(sar_result);
    endproperty
    a_result_store: assert property (p_result_store) else $error("result not stored in its channel");

    property p_conv_time;
        sar_done |-> r.conv_mc == ({5'h00, period} * 8'h0C) + 8'h01;
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

    property p_loop_flag;
        sar_done && r.st == adc_scan_pkg::SCAN_CONV && !next_ch[3] && !r.sar_abort |=> r.done_flag;
    endproperty
    a_loop_flag: assert property (p_loop_flag) else $error("done flag not set at loop end");

    property p_irq;
        r.done_flag && irq_en_i |-> irq_o ##1 (irq_o || !r.done_flag || !irq_en_i);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request not raised");

    property p_flag_hold;
        r.done_flag && !(ctl_wr && !sfr_wdata_i[adc_scan_pkg::BIT_DONE]) |=> r.done_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("done flag lost without a zero write");

    property p_flag_no_sw_set;
        !r.done_flag && !sar_done |=> !r.done_flag;
    endproperty
    a_flag_no_sw_set: assert property (p_flag_no_sw_set) else $error("done flag set without a loop end");

    property p_refuse_empty;
        !r.start_status && r.scan_select == 8'h00 |=> !r.start_status && !r.sar_start;
    endproperty
    a_refuse_empty: assert property (p_refuse_empty) else $error("start taken with nothing selected");

    property p_abort;
        r.start_status && ctl_wr && !sfr_wdata_i[adc_scan_pkg::BIT_START]
            |=> !r.start_status && r.sar_abort ##1 !sar_busy;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not stop conversion");

    property p_continuous;
        r.start_status && r.continuous_scan_sel && r.scan_select != 8'h00 && !ctl_wr |=> r.start_status;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous scan dropped start bit");

    property p_one_time_end;
        sar_done && r.st == adc_scan_pkg::SCAN_CONV && !next_ch[3] && !r.continuous_scan_sel && !ctl_wr
            |=> !r.start_status;
    endproperty
    a_one_time_end: assert property (p_one_time_end) else $error("one-time scan kept start bit");

    property p_ignore_start;
        r.start_status && r.st == adc_scan_pkg::SCAN_CONV && !sar_done && start_req
            |=> $stable(r.chan) && !r.sar_start;
    endproperty
    a_ignore_start: assert property (p_ignore_start) else $error("start request not ignored");

    property p_first_channel;
        r.sar_start && $past(r.st) == adc_scan_pkg::SCAN_IDLE |-> r.loop_mask[r.chan]
            && ((r.loop_mask & ((8'h01 << r.chan) - 8'h01)) == 8'h00);
    endproperty
    a_first_channel: assert property (p_first_channel) else $error("loop did not begin at lowest channel");

    property p_high_latch;
        sfr_rd_i && sfr_addr_i[7:3] == adc_scan_pkg::ADDR_RESULT_LOW0[7:3]
            |=> r.high_latch == $past(r.results[sfr_addr_i[2:0]][9:8]);
    endproperty
    a_high_latch: assert property (p_high_latch) else $error("high bits not latched on low read");

    c_one_time_loop: cover property (r.start_status && !r.continuous_scan_sel ##1 !r.start_status);
    c_continuous_wrap: cover property (r.continuous_scan_sel && sar_done && !next_ch[3]);
    c_trigger_start: cover property (hw_start && !r.start_status ##1 r.start_status);
    c_abort: cover property (r.sar_abort && sar_busy);

endmodule : adc_autoscan_control

// ===== dv/analog_far_end.sv
`timescale 1ns/1ps
module analog_far_end (
    input  wire logic [9:0] dac_code_i,
    input  wire logic [2:0] mux_sel_i,
    output logic            comp_o
);
    // Each channel holds a distinct fixed level, so a result lands only at its own index
    always_comb comp_o = ({7'h00, mux_sel_i} * 10'h051 + 10'h0A5) >= dac_code_i;
endmodule : analog_far_end

// ===== dv/adc_autoscan_control_test.sv
`timescale 1ns/1ps
module adc_autoscan_control_test;
    localparam int MCK = 4;
    logic clock_i, rst_b_i, sfr_wr_i, sfr_rd_i, irq_en_i, trig, irq_o, capture_o, comp, sample_o, cap, smp;
    logic [7:0] addr, wdata, rdata, port;
    logic [9:0] dac, lvl;
    logic [2:0] mux;
    int errors, compares, cycles, n;
    // Prescale code beside the channel mask
    logic [9:0] rows [4] = '{10'h0FF, 10'h15A, 10'h280, 10'h324};
    adc_autoscan_control #(.MC_CLKS(MCK)) adc_autoscan_control_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .sfr_addr_i(addr), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .irq_en_i(irq_en_i), .irq_o(irq_o), .external_trigger_in_i(trig), .capture_o(capture_o),
        .shared_input_port_i(port), .comp_i(comp), .dac_code_o(dac), .mux_sel_o(mux), .sample_o(sample_o));
    analog_far_end analog_far_end_inst (.dac_code_i(dac), .mux_sel_i(mux), .comp_o(comp));
    task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        addr = a;
        wdata = d;
        sfr_wr_i = 1'b1;
        @(negedge clock_i);
        sfr_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clock_i);
        addr = a;
        sfr_rd_i = 1'b1;
        @(negedge clock_i);
        sfr_rd_i = 1'b0;
    endtask : rd
    task automatic wait_irq();
        n = 0;
        smp = 1'b0;
        while (irq_o !== 1'b1 && n < 4000) begin
            @(negedge clock_i);
            smp |= sample_o;
            n++;
        end
        chk("irq", irq_o, 1'b1);
    endtask : wait_irq
    task automatic edge_chk(input logic v, input logic e);
        trig = v;
        cap = 1'b0;
        repeat (8) @(negedge clock_i) cap |= capture_o;
        chk("capture", cap, e);
    endtask : edge_chk
    task automatic close_out();
        if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    // Budget covers every scan below with wide margin
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        {rst_b_i, sfr_wr_i, sfr_rd_i, trig, addr, wdata, port} = '0;
        irq_en_i = 1'b1;
        repeat (20) @(negedge clock_i);
        rst_b_i = 1'b1;
        rd(8'hD7);
        chk("ctl_reset", rdata, 8'h00);
        for (int r = 0; r < 4; r++) begin
            wr(8'hE7, rows[r][7:0]);
            wr(8'hD7, {rows[r][9:8], 6'h08});
            wait_irq();
            chk("scan_time", n >= (12 * (rows[r][9:8] + 1) + 1) * MCK, 1'b1);
            chk("sample", smp, 1'b1);
            rd(8'hD7);
            chk("ctl_done", rdata, {rows[r][9:8], 6'h10});
            for (int c = 0; c < 8; c++) if (rows[r][c]) begin
                lvl = 10'h0A5 + 10'(c) * 10'h051;
                rd(8'hE8 + 8'(c));
                chk("low", rdata, lvl[7:0]);
                rd(8'hDF);
                chk("high", rdata, {6'h00, lvl[9:8]});
            end
            wr(8'hD7, 8'h00);
            chk("irq_off", irq_o, 1'b0);
        end
        port = 8'h3C;
        repeat (2) @(negedge clock_i);
        rd(8'hC7);
        chk("port", rdata, 8'h3C);
        wr(8'hE7, 8'h00);
        wr(8'hD7, 8'h08);
        rd(8'hD7);
        chk("no_sel", rdata, 8'h00);
        wr(8'hE7, 8'h03);
        wr(8'hD7, 8'h0C);
        wait_irq();
        wr(8'hD7, 8'h1C);
        rd(8'hD7);
        chk("cont", rdata, 8'h1C);
        irq_en_i = 1'b0;
        @(negedge clock_i);
        chk("irq_mask", irq_o, 1'b0);
        irq_en_i = 1'b1;
        wr(8'hD7, 8'h0C);
        wait_irq();
        repeat (12) @(negedge clock_i);
        chk("dac_busy", dac != 10'h000, 1'b1);
        wr(8'hD7, 8'h00);
        @(negedge clock_i);
        chk("abort", dac, 10'h000);
        wr(8'hD7, 8'h02);
        edge_chk(1'b1, 1'b1);
        rd(8'hD7);
        chk("trig_start", rdata, 8'h0A);
        chk("mux", mux, 3'h0);
        wait_irq();
        wr(8'hD7, 8'h00);
        edge_chk(1'b0, 1'b0);
        wr(8'hD7, 8'h01);
        edge_chk(1'b1, 1'b0);
        edge_chk(1'b0, 1'b1);
        wait_irq();
        wr(8'hD7, 8'h0C);
        repeat (10) @(negedge clock_i);
        rst_b_i = 1'b0;
        @(negedge clock_i);
        rst_b_i = 1'b1;
        rd(8'hD7);
        chk("mid_reset", rdata, 8'h00);
        chk("mid_irq", irq_o, 1'b0);
        close_out();
    end
endmodule : adc_autoscan_control_test
